// file: cie_defines.svh
// Constants of the instruction execution subset: opcodes, operands, reset values
`ifndef CIE_DEFINES_SVH
`define CIE_DEFINES_SVH

// ****************************************************************
// Widths
// ****************************************************************
`define CIE_DATA_W        8
`define CIE_ADDR_W        5
`define CIE_PC_W          11
`define CIE_OP_W          4
`define CIE_FILE_DEPTH    32

// ****************************************************************
// Opcode codes presented on op_i
// ****************************************************************
`define CIE_OP_RETURN     4'h0
`define CIE_OP_ROTL       4'h1
`define CIE_OP_ROTR       4'h2
`define CIE_OP_SLEEP      4'h3
`define CIE_OP_SUB        4'h4
`define CIE_OP_SWAP       4'h5
`define CIE_OP_DIRLOAD    4'h6
`define CIE_OP_XORL       4'h7
`define CIE_OP_XORF       4'h8

// ****************************************************************
// Direction register operands
// ****************************************************************
`define CIE_DIR_SEL_A     5'h06
`define CIE_DIR_SEL_B     5'h07
`define CIE_DIR_SEL_C     5'h08

// ****************************************************************
// Reset values
// ****************************************************************
`define CIE_RST_BYTE      8'h00
`define CIE_RST_DIR       8'hFF
`define CIE_RST_PC        11'h000
`define CIE_RST_TO        1'h1
`define CIE_RST_PD        1'h1

`endif

// file: cie_pkg.sv
// Types of the instruction execution subset
package cie_pkg;

  // ****************************************************************
  // Sequencer states
  // ****************************************************************
  typedef enum logic [1:0] {
    CIE_ST_IDLE,
    CIE_ST_EXEC,
    CIE_ST_RET2,
    CIE_ST_SLEEP
  } cie_state_t;

  // ****************************************************************
  // Whole state of the execution unit
  // ****************************************************************
  typedef struct packed {
    cie_state_t  state;
    logic [3:0]  op;
    logic [4:0]  addr;
    logic        dest;
    logic        ready;
    logic        illegal;
    logic        stack_pop;
    logic        pc_load;
    logic [10:0] pc;
    logic        wdt_clear;
    logic        presc_clear;
    logic        sleep;
    logic [7:0]  w;
    logic        carry;
    logic        half_carry;
    logic        zero;
    logic        timeout;
    logic        powerdown;
    logic [7:0]  dir_a;
    logic [7:0]  dir_b;
    logic [7:0]  dir_c;
    logic        file_wr;
    logic [4:0]  file_wr_addr;
    logic [7:0]  file_wr_data;
  } cie_regs_t;

endpackage

// file: cie_file_ram.sv
// File register memory, 32 bytes, registered read data
`timescale 1ns/100ps
`include "cie_defines.svh"

module cie_file_ram (
  // Clock and reset
  input  wire logic                     ref_clk_i,
  input  wire logic                     reset_n_i,
  // Write port
  input  wire logic                     we_i,
  input  wire logic [`CIE_ADDR_W-1:0]   waddr_i,
  input  wire logic [`CIE_DATA_W-1:0]   wdata_i,
  // Read port
  input  wire logic [`CIE_ADDR_W-1:0]   raddr_i,
  output logic      [`CIE_DATA_W-1:0]   rdata_o
);

  logic [`CIE_DATA_W-1:0] mem [`CIE_FILE_DEPTH];

  // Storage array, no reset
  always_ff @(posedge ref_clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
  end

  // Registered read, old data on same-cycle write
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_o <= `CIE_RST_BYTE;
    end else begin
      rdata_o <= mem[raddr_i];
    end
  end

endmodule

// file: cie_exec.sv
// Execution unit for return, rotates, subtract, swap, xor, direction load, sleep
`timescale 1ns/100ps
`include "cie_defines.svh"

module cie_exec (
  // Clock and reset
  input  wire logic                     ref_clk_i,
  input  wire logic                     reset_n_i,
  // Instruction issue
  input  wire logic                     instr_valid_i,
  input  wire logic [`CIE_OP_W-1:0]     op_i,
  input  wire logic [`CIE_ADDR_W-1:0]   f_addr_i,
  input  wire logic                     dest_i,
  input  wire logic [`CIE_DATA_W-1:0]   literal_i,
  output logic                          ready_o,
  output logic                          illegal_o,
  // Return stack and program counter
  input  wire logic [`CIE_PC_W-1:0]     stack_top_i,
  output logic                          stack_pop_o,
  output logic                          pc_load_o,
  output logic      [`CIE_PC_W-1:0]     pc_o,
  // Watchdog and sleep
  input  wire logic                     wake_i,
  output logic                          watchdog_counter_clear_o,
  output logic                          prescaler_clear_o,
  output logic                          sleep_o,
  // Accumulator and status flags
  output logic      [`CIE_DATA_W-1:0]   w_o,
  output logic                          carry_o,
  output logic                          half_carry_o,
  output logic                          zero_o,
  output logic                          timeout_status_flag_o,
  output logic                          powerdown_flag_o,
  // Port direction registers
  output logic      [`CIE_DATA_W-1:0]   dir_a_o,
  output logic      [`CIE_DATA_W-1:0]   dir_b_o,
  output logic      [`CIE_DATA_W-1:0]   dir_c_o,
  // File register seeding
  input  wire logic                     seed_we_i,
  input  wire logic [`CIE_ADDR_W-1:0]   seed_addr_i,
  input  wire logic [`CIE_DATA_W-1:0]   seed_data_i,
  // File register write observation
  output logic                          file_wr_o,
  output logic      [`CIE_ADDR_W-1:0]   file_wr_addr_o,
  output logic      [`CIE_DATA_W-1:0]   file_wr_data_o
);

  // ****************************************************************
  // Helpers
  // ****************************************************************

  // Zero test of an 8-bit result
  function automatic logic is_zero(input logic [7:0] val);
    is_zero = (val == 8'h00);
  endfunction

  // ****************************************************************
  // Signals
  // ****************************************************************
  cie_pkg::cie_regs_t      st;
  cie_pkg::cie_regs_t      next_st;
  logic                    ram_we;
  logic [`CIE_ADDR_W-1:0]  ram_waddr;
  logic [`CIE_DATA_W-1:0]  ram_wdata;
  logic [`CIE_ADDR_W-1:0]  ram_raddr;
  logic [`CIE_DATA_W-1:0]  ram_rdata;
  logic [8:0]              sub_sum;
  logic [4:0]              sub_nib;
  logic [7:0]              result;

  // ****************************************************************
  // File register memory
  // ****************************************************************
  cie_file_ram u_file_ram (
    .ref_clk_i (ref_clk_i),
    .reset_n_i (reset_n_i),
    .we_i      (ram_we),
    .waddr_i   (ram_waddr),
    .wdata_i   (ram_wdata),
    .raddr_i   (ram_raddr),
    .rdata_o   (ram_rdata)
  );

  // Two's-complement subtract, file minus accumulator
  assign sub_sum = {1'b0, ram_rdata} + {1'b0, ~st.w} + 9'h001;
  assign sub_nib = {1'b0, ram_rdata[3:0]} + {1'b0, ~st.w[3:0]} + 5'h01;

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb begin
    next_st             = st;
    next_st.illegal     = 1'b0;
    next_st.stack_pop   = 1'b0;
    next_st.pc_load     = 1'b0;
    next_st.wdt_clear   = 1'b0;
    next_st.presc_clear = 1'b0;
    next_st.file_wr     = 1'b0;
    ram_we              = 1'b0;
    ram_waddr           = st.addr;
    ram_wdata           = `CIE_RST_BYTE;
    ram_raddr           = f_addr_i;
    result              = `CIE_RST_BYTE;
    case (st.state)
      cie_pkg::CIE_ST_IDLE: begin
        // Seed path into the file registers
        if (seed_we_i) begin
          ram_we    = 1'b1;
          ram_waddr = seed_addr_i;
          ram_wdata = seed_data_i;
        end
        if (instr_valid_i) begin
          next_st.op   = op_i;
          next_st.addr = f_addr_i;
          next_st.dest = dest_i;
          case (op_i)
            `CIE_OP_RETURN: begin
              next_st.stack_pop = 1'b1;
              next_st.state     = cie_pkg::CIE_ST_RET2;
            end
            `CIE_OP_ROTL, `CIE_OP_ROTR, `CIE_OP_SUB, `CIE_OP_SWAP, `CIE_OP_XORF: begin
              next_st.state = cie_pkg::CIE_ST_EXEC;
            end
            `CIE_OP_XORL: begin
              next_st.w    = st.w ^ literal_i;
              next_st.zero = is_zero(st.w ^ literal_i);
            end
            `CIE_OP_DIRLOAD: begin
              // Direction registers only, no flag touched
              case (f_addr_i)
                `CIE_DIR_SEL_A: next_st.dir_a = st.w;
                `CIE_DIR_SEL_B: next_st.dir_b = st.w;
                `CIE_DIR_SEL_C: next_st.dir_c = st.w;
                default:        next_st.illegal = 1'b1;
              endcase
            end
            `CIE_OP_SLEEP: begin
              next_st.wdt_clear   = 1'b1;
              next_st.presc_clear = 1'b1;
              next_st.timeout     = 1'b1;
              next_st.powerdown   = 1'b0;
              next_st.sleep       = 1'b1;
              next_st.state       = cie_pkg::CIE_ST_SLEEP;
            end
            default: begin
              next_st.illegal = 1'b1;
            end
          endcase
        end
      end
      cie_pkg::CIE_ST_EXEC: begin
        // File operand is now out of the memory
        case (st.op)
          `CIE_OP_ROTL: begin
            result        = {ram_rdata[6:0], st.carry};
            next_st.carry = ram_rdata[7];
          end
          `CIE_OP_ROTR: begin
            result        = {st.carry, ram_rdata[7:1]};
            next_st.carry = ram_rdata[0];
          end
          `CIE_OP_SUB: begin
            result             = sub_sum[7:0];
            next_st.carry      = sub_sum[8];
            next_st.half_carry = sub_nib[4];
            next_st.zero       = is_zero(sub_sum[7:0]);
          end
          `CIE_OP_SWAP: begin
            result = {ram_rdata[3:0], ram_rdata[7:4]};
          end
          default: begin
            result       = st.w ^ ram_rdata;
            next_st.zero = is_zero(st.w ^ ram_rdata);
          end
        endcase
        // Route by destination bit
        if (st.dest) begin
          ram_we               = 1'b1;
          ram_wdata            = result;
          next_st.file_wr      = 1'b1;
          next_st.file_wr_addr = st.addr;
          next_st.file_wr_data = result;
        end else begin
          next_st.w = result;
        end
        next_st.state = cie_pkg::CIE_ST_IDLE;
      end
      cie_pkg::CIE_ST_RET2: begin
        // Second cycle of return
        next_st.pc      = stack_top_i;
        next_st.pc_load = 1'b1;
        next_st.state   = cie_pkg::CIE_ST_IDLE;
      end
      cie_pkg::CIE_ST_SLEEP: begin
        // Halted until woken
        if (wake_i) begin
          next_st.sleep = 1'b0;
          next_st.state = cie_pkg::CIE_ST_IDLE;
        end
      end
      default: begin
        next_st.state = cie_pkg::CIE_ST_IDLE;
      end
    endcase
    next_st.ready = (next_st.state == cie_pkg::CIE_ST_IDLE);
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st              <= '0;
      st.state        <= cie_pkg::CIE_ST_IDLE;
      st.ready        <= 1'b1;
      st.pc           <= `CIE_RST_PC;
      st.timeout      <= `CIE_RST_TO;
      st.powerdown    <= `CIE_RST_PD;
      st.dir_a        <= `CIE_RST_DIR;
      st.dir_b        <= `CIE_RST_DIR;
      st.dir_c        <= `CIE_RST_DIR;
    end else begin
      st <= next_st;
    end
  end

  // ****************************************************************
  // Outputs, all from the state register
  // ****************************************************************
  assign ready_o                  = st.ready;
  assign illegal_o                = st.illegal;
  assign stack_pop_o              = st.stack_pop;
  assign pc_load_o                = st.pc_load;
  assign pc_o                     = st.pc;
  assign watchdog_counter_clear_o = st.wdt_clear;
  assign prescaler_clear_o        = st.presc_clear;
  assign sleep_o                  = st.sleep;
  assign w_o                      = st.w;
  assign carry_o                  = st.carry;
  assign half_carry_o             = st.half_carry;
  assign zero_o                   = st.zero;
  assign timeout_status_flag_o    = st.timeout;
  assign powerdown_flag_o         = st.powerdown;
  assign dir_a_o                  = st.dir_a;
  assign dir_b_o                  = st.dir_b;
  assign dir_c_o                  = st.dir_c;
  assign file_wr_o                = st.file_wr;
  assign file_wr_addr_o           = st.file_wr_addr;
  assign file_wr_data_o           = st.file_wr_data;

endmodule

// file: cie_exec_properties.sv
// Concurrent checks of the execution unit ports
`timescale 1ns/100ps
`include "cie_defines.svh"
module cie_exec_props (
  // Clock, reset and issue
  input wire logic        ref_clk_i,
  input wire logic        reset_n_i,
  input wire logic        instr_valid_i,
  input wire logic [3:0]  op_i,
  input wire logic [4:0]  f_addr_i,
  input wire logic        dest_i,
  input wire logic [7:0]  literal_i,
  input wire logic        ready_o,
  // Stack and sleep
  input wire logic [10:0] stack_top_i,
  input wire logic        stack_pop_o,
  input wire logic        pc_load_o,
  input wire logic [10:0] pc_o,
  input wire logic        watchdog_counter_clear_o,
  input wire logic        prescaler_clear_o,
  input wire logic        sleep_o,
  // Data and flags
  input wire logic [7:0]  w_o,
  input wire logic        carry_o,
  input wire logic        half_carry_o,
  input wire logic        zero_o,
  input wire logic        timeout_status_flag_o,
  input wire logic        powerdown_flag_o,
  input wire logic [7:0]  dir_a_o,
  input wire logic [7:0]  dir_b_o,
  input wire logic [7:0]  dir_c_o,
  input wire logic        file_wr_o,
  input wire logic [4:0]  file_wr_addr_o
);
  // ****
  // Issue strobe and flag group
  // ****
  wire       tk = ready_o & instr_valid_i;
  wire [2:0] fl = {carry_o, half_carry_o, zero_o};
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);
  AST_RET_PC: assert property (tk && op_i == `CIE_OP_RETURN
    |=> stack_pop_o && !ready_o ##1 pc_load_o && pc_o == $past(stack_top_i))
    else $error("return did not load pc from stack top");
  AST_RET_FL: assert property (tk && op_i == `CIE_OP_RETURN
    |-> ##2 fl == $past(fl, 2)) else $error("return changed flags");
  AST_SLP_CLR: assert property (tk && op_i == `CIE_OP_SLEEP
    |=> watchdog_counter_clear_o && prescaler_clear_o && sleep_o
    ##1 !watchdog_counter_clear_o) else $error("sleep clear pulses wrong");
  AST_SLP_FL: assert property (tk && op_i == `CIE_OP_SLEEP
    |=> timeout_status_flag_o && !powerdown_flag_o && $stable(fl))
    else $error("sleep status flags wrong");
  AST_XORL: assert property (tk && op_i == `CIE_OP_XORL
    |=> w_o == $past(w_o ^ literal_i) && zero_o == (w_o == 8'h00)
    && $stable(fl[2:1])) else $error("literal xor wrong");
  AST_SWAP_FL: assert property (tk && op_i == `CIE_OP_SWAP
    |-> ##2 fl == $past(fl, 2)) else $error("swap changed flags");
  AST_ROT_FL: assert property (tk && op_i inside {1, 2}
    |-> ##2 fl[1:0] == $past(fl[1:0], 2)) else $error("rotate touched dc or z");
  AST_XORF_FL: assert property (tk && op_i == `CIE_OP_XORF
    |-> ##2 fl[2:1] == $past(fl[2:1], 2)) else $error("file xor touched c or dc");
  AST_DEST: assert property (tk && op_i inside {1, 2, 4, 5, 8}
    |-> ##2 file_wr_o == $past(dest_i, 2)
    && (!file_wr_o || file_wr_addr_o == $past(f_addr_i, 2)))
    else $error("destination routing wrong");
  AST_DIR: assert property (tk && op_i == `CIE_OP_DIRLOAD && f_addr_i inside {6, 7, 8}
    |=> ($past(f_addr_i) == 6 ? dir_a_o : $past(f_addr_i) == 7 ? dir_b_o : dir_c_o)
    == $past(w_o) && $stable(fl)) else $error("direction load wrong");
  // Main scenarios reached
  COV_RET: cover property (pc_load_o);
  COV_SLP: cover property (sleep_o ##1 !sleep_o);
  COV_WR: cover property (file_wr_o);
endmodule

bind cie_exec cie_exec_props i_props (.*);

// file: cie_stack_model.sv
// Return stack model feeding the execution unit
`timescale 1ns/100ps
module cie_stack_model #(
  parameter logic [10:0] TOP0 = 11'h5A3,
  parameter logic [10:0] TOP1 = 11'h0FF
) (
  // Clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        reset_n_i,
  // Stack port
  input  wire logic        stack_pop_i,
  output logic      [10:0] stack_top_o
);
  // Each pop moves to the other stored level
  logic sp;
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) sp <= 1'b0;
    else if (stack_pop_i) sp <= ~sp;
  end
  assign stack_top_o = sp ? TOP1 : TOP0;
endmodule

// file: test_core_instruction_exec_subset.sv
// Self-checking bench of the execution unit
`timescale 1ns/100ps
`include "cie_defines.svh"
module test_core_instruction_exec_subset;
  // ****
  // Stimulus, responses and model
  // ****
  logic ref_clk_i = 0, reset_n_i = 0, instr_valid_i = 0, dest_i = 0, wake_i = 0, seed_we_i = 0;
  logic [3:0] op_i = 0;
  logic [4:0] f_addr_i = 0, seed_addr_i = 0, file_wr_addr_o;
  logic [7:0] literal_i = 0, seed_data_i = 0, w_o, dir_a_o, dir_b_o, dir_c_o, file_wr_data_o;
  logic [10:0] stack_top_i, pc_o;
  logic ready_o, illegal_o, stack_pop_o, pc_load_o, watchdog_counter_clear_o, prescaler_clear_o;
  logic sleep_o, carry_o, half_carry_o, zero_o, timeout_status_flag_o, powerdown_flag_o, file_wr_o;
  logic [7:0] m [32];
  logic [7:0] mw = 0;
  logic mc = 0, mdc = 0, mz = 0;
  int error_cnt = 0, num_checks = 0;
  // Device and stack
  cie_exec i_dut (.*);
  cie_stack_model i_stk (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
    .stack_pop_i(stack_pop_o), .stack_top_o(stack_top_i));
  always #5 ref_clk_i = ~ref_clk_i;
  // Common helpers
  task automatic chk(input string n, input logic [10:0] e, input logic [10:0] g);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic st();
    chk("w", mw, w_o);
    chk("c", mc, carry_o);
    chk("dc", mdc, half_carry_o);
    chk("z", mz, zero_o);
  endtask
  task automatic issue(input logic [3:0] o, input logic [4:0] a, input logic d, input logic [7:0] k);
    @(posedge ref_clk_i);
    instr_valid_i <= 1; op_i <= o; f_addr_i <= a; dest_i <= d; literal_i <= k;
    @(posedge ref_clk_i);
    instr_valid_i <= 0;
    #1;
  endtask
  task automatic seed(input logic [4:0] a, input logic [7:0] v);
    @(posedge ref_clk_i);
    seed_we_i <= 1; seed_addr_i <= a; seed_data_i <= v;
    @(posedge ref_clk_i);
    seed_we_i <= 0;
    m[a] = v;
  endtask
  // One data instruction against the model
  task automatic alu(input logic [3:0] o, input logic [4:0] a, input logic d, input logic [7:0] k);
    logic [7:0] f, r;
    logic [8:0] s;
    logic [4:0] h;
    f = m[a];
    case (o)
      `CIE_OP_ROTL: begin r = {f[6:0], mc}; mc = f[7]; end
      `CIE_OP_ROTR: begin r = {mc, f[7:1]}; mc = f[0]; end
      `CIE_OP_SWAP: r = {f[3:0], f[7:4]};
      `CIE_OP_SUB: begin
        s = {1'b0, f} + {1'b0, ~mw} + 9'h001;
        h = {1'b0, f[3:0]} + {1'b0, ~mw[3:0]} + 5'h01;
        r = s[7:0]; mc = s[8]; mdc = h[4]; mz = (r == 8'h00);
      end
      `CIE_OP_XORL: begin r = mw ^ k; mz = (r == 8'h00); end
      default: begin r = mw ^ f; mz = (r == 8'h00); end
    endcase
    issue(o, a, d, k);
    if (o != `CIE_OP_XORL) begin
      chk("busy", 0, ready_o);
      @(posedge ref_clk_i);
      #1;
    end
    if (d) begin
      m[a] = r;
      chk("wr_data", r, file_wr_data_o);
      chk("wr_addr", a, file_wr_addr_o);
    end else mw = r;
    chk("wr", d, file_wr_o);
    chk("ready", 1, ready_o);
    st();
  endtask
  // ****
  // Scenarios
  // ****
  task automatic t_rot();
    seed(5, 8'h81);
    seed(6, 8'h01);
    alu(`CIE_OP_ROTL, 5, 1, 0);
    alu(`CIE_OP_ROTL, 5, 0, 0);
    alu(`CIE_OP_ROTR, 6, 1, 0);
    alu(`CIE_OP_ROTR, 6, 0, 0);
  endtask
  task automatic t_sub();
    alu(`CIE_OP_XORL, 0, 0, 8'h91);
    seed(7, 8'h11);
    seed(8, 8'h10);
    seed(9, 8'h28);
    alu(`CIE_OP_XORL, 0, 0, 8'h80);
    alu(`CIE_OP_SUB, 7, 1, 0);
    alu(`CIE_OP_SUB, 8, 1, 0);
    alu(`CIE_OP_SUB, 9, 0, 0);
  endtask
  task automatic t_swx();
    seed(10, 8'hA5);
    alu(`CIE_OP_SWAP, 10, 0, 0);
    alu(`CIE_OP_SWAP, 10, 1, 0);
    alu(`CIE_OP_XORF, 10, 1, 0);
    alu(`CIE_OP_XORF, 10, 0, 0);
    alu(`CIE_OP_XORL, 0, 0, mw);
  endtask
  task automatic t_dir();
    logic [7:0] e [3];
    e = '{8'hFF, 8'hFF, 8'hFF};
    for (int s = 6; s <= 8; s++) begin
      alu(`CIE_OP_XORL, 0, 0, 8'h3C + s[7:0]);
      issue(`CIE_OP_DIRLOAD, s[4:0], 0, 0);
      e[s - 6] = mw;
      chk("dir_a", e[0], dir_a_o);
      chk("dir_b", e[1], dir_b_o);
      chk("dir_c", e[2], dir_c_o);
      st();
    end
    issue(`CIE_OP_DIRLOAD, 9, 0, 0);
    chk("illegal", 1, illegal_o);
    issue(4'hF, 0, 0, 0);
    chk("illegal", 1, illegal_o);
    chk("dir_a", e[0], dir_a_o);
  endtask
  task automatic t_ret();
    for (int i = 0; i < 2; i++) begin
      issue(`CIE_OP_RETURN, 0, 0, 0);
      chk("pop", 1, stack_pop_o);
      chk("ready", 0, ready_o);
      @(posedge ref_clk_i);
      #1;
      chk("pc_load", 1, pc_load_o);
      chk("pc", i ? 11'h0FF : 11'h5A3, pc_o);
      st();
    end
  endtask
  task automatic t_sleep();
    issue(`CIE_OP_SLEEP, 0, 0, 0);
    chk("sleep", 1, sleep_o);
    chk("wdt_clr", 1, watchdog_counter_clear_o);
    chk("presc_clr", 1, prescaler_clear_o);
    chk("to", 1, timeout_status_flag_o);
    chk("pd", 0, powerdown_flag_o);
    st();
    issue(`CIE_OP_XORL, 0, 0, 8'h5A);
    chk("halted", mw, w_o);
    @(posedge ref_clk_i);
    wake_i <= 1;
    @(posedge ref_clk_i);
    wake_i <= 0;
    #1;
    chk("sleep", 0, sleep_o);
    chk("ready", 1, ready_o);
    chk("pd_hold", 0, powerdown_flag_o);
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (16) @(posedge ref_clk_i);
    chk("rst_ready", 1, ready_o);
    chk("rst_dir", 8'hFF, dir_b_o);
    chk("rst_pd", 1, powerdown_flag_o);
    chk("rst_to", 1, timeout_status_flag_o);
    chk("rst_pc", 0, pc_o);
    reset_n_i <= 1;
    t_rot();
    t_sub();
    t_swx();
    t_dir();
    t_ret();
    t_sleep();
    print_verdict();
  end
  // Watchdog
  initial begin
    repeat (3000) @(posedge ref_clk_i);
    error_cnt++;
    print_verdict();
  end
endmodule
